// ==== pkg/fiq_defs.svh ====
// Constants for the flash identifier and status query controller
`ifndef FIQ_DEFS_SVH
`define FIQ_DEFS_SVH
// ----------------------------------------------------------------
// Commands and query addresses
// ----------------------------------------------------------------
`define FIQ_CMD_READ_ARRAY 8'hFF
`define FIQ_CMD_READ_ID 8'h90
`define FIQ_CMD_READ_STATUS 8'h70
`define FIQ_CMD_READ_QUERY 8'h98
`define FIQ_QRY_PROT_COUNT 8'h3F
`define FIQ_QRY_PROT_DESC 8'h40
`define FIQ_QRY_PAGE_CAP 8'h44
`define FIQ_QRY_BURST_CNT 8'h45
`define FIQ_QRY_RESERVED 8'h46
`define FIQ_ID_MANUF 8'h00
`define FIQ_ID_DEVICE 8'h01
`define FIQ_ID_LOCK 8'h02
`define FIQ_ENGINE_READY_BIT 7
`define FIQ_LOCK_BIT 0
`define FIQ_PROT_ZERO_BYTES 16'h0100
// ----------------------------------------------------------------
// Register offsets of the controller port
// ----------------------------------------------------------------
`define FIQ_REG_CTRL 4'h0
`define FIQ_REG_ADDR 4'h1
`define FIQ_REG_STAT 4'h2
`define FIQ_REG_DATA 4'h3
`define FIQ_REG_PAGE 4'h4
`define FIQ_REG_PROT 4'h5
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FIQ_CLK_NS 8
`define FIQ_T_ACCESS_NS 120
`define FIQ_T_WRITE_NS 70
`define FIQ_T_HIGH_NS 30
`endif

// ==== pkg/fiq_pkg.sv ====
// Types for the flash identifier and status query controller
package fiq_pkg;
  typedef enum logic [2:0] {
    FIQ_OP_CMD,
    FIQ_OP_ID,
    FIQ_OP_STATUS,
    FIQ_OP_QUERY,
    FIQ_OP_ARRAY
  } fiq_op_e;
  typedef enum logic [1:0] {
    FIQ_MODE_ARRAY,
    FIQ_MODE_ID,
    FIQ_MODE_STATUS,
    FIQ_MODE_QUERY
  } fiq_mode_e;
endpackage : fiq_pkg

// ==== src/fiq_cycle.sv ====
// Single asynchronous flash bus cycle: strobe timing and the sample pulse for data capture
`timescale 1ns/100ps
`default_nettype none
`include "fiq_defs.svh"
module fiq_cycle
  import fiq_pkg::*;
#(
  parameter int ACC_CYC = (`FIQ_T_ACCESS_NS + `FIQ_CLK_NS - 1) / `FIQ_CLK_NS,
  parameter int WR_CYC = (`FIQ_T_WRITE_NS + `FIQ_CLK_NS - 1) / `FIQ_CLK_NS,
  parameter int HI_CYC = (`FIQ_T_HIGH_NS + `FIQ_CLK_NS - 1) / `FIQ_CLK_NS
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic i_write,
  output logic o_busy,
  output logic o_done,
  output logic o_sample,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_dq_oe_n
);
  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {FIQ_PH_IDLE, FIQ_PH_ACT, FIQ_PH_HIGH} fiq_ph_e;
  fiq_ph_e ph_reg, ph_next; // Current phase
  logic [7:0] cnt_reg, cnt_next; // Phase counter
  logic wr_reg, wr_next; // Cycle is a write
  logic done_reg, done_next; // Completion pulse
  logic smp_reg, smp_next; // Sample pulse
  // Next-state logic; strobes go high between cycles so each read is a new random access
  always_comb begin
    ph_next = ph_reg;
    cnt_next = cnt_reg;
    wr_next = wr_reg;
    done_next = 1'b0;
    smp_next = 1'b0;
    unique case (ph_reg)
      FIQ_PH_IDLE: begin
        if (i_start) begin
          ph_next = FIQ_PH_ACT;
          wr_next = i_write;
          cnt_next = '0;
        end
      end
      FIQ_PH_ACT: begin
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == 8'((wr_reg ? WR_CYC : ACC_CYC) - 1)) begin
          ph_next = FIQ_PH_HIGH;
          cnt_next = '0;
          smp_next = ~wr_reg;
        end
      end
      FIQ_PH_HIGH: begin
        // Deselect before the next access so status is relatched
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == 8'(HI_CYC - 1)) begin
          ph_next = FIQ_PH_IDLE;
          done_next = 1'b1;
        end
      end
    endcase
  end
  // Registers
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      ph_reg <= FIQ_PH_IDLE;
      cnt_reg <= '0;
      wr_reg <= 1'b0;
      done_reg <= 1'b0;
      smp_reg <= 1'b0;
    end else begin
      ph_reg <= ph_next;
      cnt_reg <= cnt_next;
      wr_reg <= wr_next;
      done_reg <= done_next;
      smp_reg <= smp_next;
    end
  end
  assign o_busy = (ph_reg != FIQ_PH_IDLE);
  assign o_done = done_reg;
  assign o_sample = smp_reg;
  assign o_ce_n = (ph_reg != FIQ_PH_ACT);
  assign o_oe_n = !((ph_reg == FIQ_PH_ACT) && !wr_reg);
  assign o_we_n = !((ph_reg == FIQ_PH_ACT) && wr_reg);
  assign o_dq_oe_n = !((ph_reg != FIQ_PH_IDLE) && wr_reg);
endmodule : fiq_cycle
`default_nettype wire

// ==== src/fiq_ctrl.sv ====
// Host controller that reads identifier, status and query data from a parallel flash
// Functional notes
// - Only single random reads in these modes
// - Identifier mode lasts until new command
// - Identifier command only when engine idle
// - Deselect between status reads for freshness
// - Address bit 0 ignored, A1 lowest, in identifier and query modes only
`timescale 1ns/100ps
`default_nettype none
`include "fiq_defs.svh"
module fiq_ctrl
  import fiq_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  output logic [31:0] o_reg_rdata,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic [ADDR_W-1:0] o_addr,
  output logic [15:0] o_dq_out,
  output logic o_dq_oe_n,
  input wire logic [15:0] i_dq_in
);
  // ----------------------------------------------------------------
  // Input synchroniser for the data pins
  // ----------------------------------------------------------------
  logic [15:0] dq_s1_reg, dq_s2_reg; // Two-stage capture of the pins
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      dq_s1_reg <= 16'h0000;
      dq_s2_reg <= 16'h0000;
    end else begin
      dq_s1_reg <= i_dq_in;
      dq_s2_reg <= dq_s1_reg;
    end
  end
  // ----------------------------------------------------------------
  // Bus cycle engine
  // ----------------------------------------------------------------
  logic cyc_start, cyc_write, cyc_busy, cyc_done, cyc_sample;
  logic ce_n_w, oe_n_w, we_n_w, dqoe_n_w;
  fiq_cycle i_fiq_cycle (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_start(cyc_start),
    .i_write(cyc_write),
    .o_busy(cyc_busy),
    .o_done(cyc_done),
    .o_sample(cyc_sample),
    .o_ce_n(ce_n_w),
    .o_oe_n(oe_n_w),
    .o_we_n(we_n_w),
    .o_dq_oe_n(dqoe_n_w)
  );
  // Identifier address: block bits kept, word index on A1 upward, A0 forced low
  // OR-ing the index into the raw address would set A0 and shift the offset
  function automatic logic [ADDR_W-1:0] id_addr(input logic [ADDR_W-1:0] blk, input logic [7:0] idx);
    id_addr = {blk[ADDR_W-1:9], idx, 1'b0};
  endfunction : id_addr
  // ----------------------------------------------------------------
  // Order sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {FIQ_ST_IDLE, FIQ_ST_CMD, FIQ_ST_READ, FIQ_ST_WAIT} fiq_st_e;
  fiq_st_e st_reg, st_next; // Sequencer state
  fiq_op_e op_reg, op_next; // Requested operation
  fiq_mode_e mode_reg, mode_next; // Device read mode as last commanded
  logic [ADDR_W-1:0] tgt_reg, tgt_next; // Target address from software
  logic [ADDR_W-1:0] addr_reg, addr_next; // Pin address
  logic [15:0] dout_reg, dout_next; // Pin write data
  logic [15:0] data_reg, data_next; // Last value read
  logic busy_reg, busy_next; // Order in progress
  logic refused_reg, refused_next; // Identifier order refused while engine busy
  logic locked_reg, locked_next; // Bit 0 of the last identifier word read, whichever word
  logic ready_reg, ready_next; // Last ready bit seen
  logic stat_valid_reg, stat_valid_next; // Low status bits are meaningful
  logic cmd_ph_reg, cmd_ph_next; // Status poll before identifier order
  logic [15:0] prot_reg, prot_next; // Decoded protection byte count
  logic [7:0] page_reg, page_next; // Decoded read page bytes
  // Command byte for each operation
  function automatic logic [7:0] op_cmd(input fiq_op_e op);
    unique case (op)
      FIQ_OP_ID: op_cmd = `FIQ_CMD_READ_ID;
      FIQ_OP_STATUS: op_cmd = `FIQ_CMD_READ_STATUS;
      FIQ_OP_QUERY: op_cmd = `FIQ_CMD_READ_QUERY;
      FIQ_OP_ARRAY: op_cmd = `FIQ_CMD_READ_ARRAY;
      FIQ_OP_CMD: op_cmd = `FIQ_CMD_READ_STATUS;
      // Undefined order codes fall back to a harmless status command
      default: op_cmd = `FIQ_CMD_READ_STATUS;
    endcase
  endfunction : op_cmd
  // Mode that a command leaves the device in
  function automatic fiq_mode_e op_mode(input fiq_op_e op);
    unique case (op)
      FIQ_OP_ID: op_mode = FIQ_MODE_ID;
      FIQ_OP_QUERY: op_mode = FIQ_MODE_QUERY;
      FIQ_OP_ARRAY: op_mode = FIQ_MODE_ARRAY;
      FIQ_OP_STATUS, FIQ_OP_CMD: op_mode = FIQ_MODE_STATUS;
      default: op_mode = FIQ_MODE_STATUS;
    endcase
  endfunction : op_mode
  // Next-state logic of the sequencer
  always_comb begin
    st_next = st_reg;
    op_next = op_reg;
    mode_next = mode_reg;
    tgt_next = tgt_reg;
    addr_next = addr_reg;
    dout_next = dout_reg;
    data_next = data_reg;
    busy_next = busy_reg;
    refused_next = refused_reg;
    locked_next = locked_reg;
    ready_next = ready_reg;
    stat_valid_next = stat_valid_reg;
    cmd_ph_next = cmd_ph_reg;
    prot_next = prot_reg;
    page_next = page_reg;
    cyc_start = 1'b0;
    cyc_write = 1'b0;
    if (i_reg_write && i_reg_addr == `FIQ_REG_ADDR && !busy_reg) begin
      tgt_next = i_reg_wdata[ADDR_W-1:0];
    end
    unique case (st_reg)
      FIQ_ST_IDLE: begin
        if (i_reg_write && i_reg_addr == `FIQ_REG_CTRL) begin
          op_next = fiq_op_e'(i_reg_wdata[2:0]);
          busy_next = 1'b1;
          refused_next = 1'b0;
          // Identifier order first checks engine state through status
          cmd_ph_next = (fiq_op_e'(i_reg_wdata[2:0]) == FIQ_OP_ID);
          st_next = FIQ_ST_CMD;
        end
      end
      FIQ_ST_CMD: begin
        // Mode changes only by a command write
        dout_next = {8'h00, op_cmd(cmd_ph_reg ? FIQ_OP_STATUS : op_reg)};
        mode_next = op_mode(cmd_ph_reg ? FIQ_OP_STATUS : op_reg);
        cyc_start = 1'b1;
        cyc_write = 1'b1;
        st_next = FIQ_ST_WAIT;
      end
      FIQ_ST_READ: begin
        // Each read is one random access, no page bursts
        unique case (mode_reg)
          FIQ_MODE_ID: addr_next = id_addr(tgt_reg, tgt_reg[7:0]);
          FIQ_MODE_QUERY: addr_next = ADDR_W'({tgt_reg[7:0], 1'b0});
          default: addr_next = tgt_reg;
        endcase
        cyc_start = 1'b1;
        st_next = FIQ_ST_WAIT;
      end
      FIQ_ST_WAIT: begin
        if (cyc_sample) begin
          if (mode_reg == FIQ_MODE_STATUS) begin
            // Busy engine drives only the ready bit
            ready_next = dq_s2_reg[`FIQ_ENGINE_READY_BIT];
            stat_valid_next = dq_s2_reg[`FIQ_ENGINE_READY_BIT];
            data_next = dq_s2_reg[`FIQ_ENGINE_READY_BIT] ? {8'h00, dq_s2_reg[7:0]} :
                        {8'h00, 8'h80 & dq_s2_reg[7:0]};
          end else if (mode_reg == FIQ_MODE_ID) begin
            data_next = {8'h00, dq_s2_reg[7:0]};
            locked_next = dq_s2_reg[`FIQ_LOCK_BIT];
          end else if (mode_reg == FIQ_MODE_QUERY) begin
            data_next = {8'h00, dq_s2_reg[7:0]};
            unique case (tgt_reg[7:0])
              `FIQ_QRY_PROT_COUNT: prot_next = (dq_s2_reg[7:0] == 8'h00) ? `FIQ_PROT_ZERO_BYTES :
                                               {8'h00, dq_s2_reg[7:0]};
              `FIQ_QRY_PAGE_CAP: page_next = (dq_s2_reg[7:0] == 8'h00) ? 8'h00 :
                                             8'(16'h0001 << dq_s2_reg[2:0]);
              // Descriptor bytes and burst count returned raw; reserved byte masked
              `FIQ_QRY_RESERVED: data_next = 16'h0000;
              default: data_next = {8'h00, dq_s2_reg[7:0]};
            endcase
          end else begin
            data_next = dq_s2_reg;
          end
        end
        if (cyc_done) begin
          if (cmd_ph_reg) begin
            st_next = FIQ_ST_READ;
          end else if (op_reg == FIQ_OP_CMD || dout_reg == 16'h0000) begin
            st_next = FIQ_ST_IDLE;
            busy_next = 1'b0;
          end else begin
            st_next = FIQ_ST_IDLE;
            busy_next = 1'b0;
          end
          // After a command write go read; after a read finish
          if (dout_reg != 16'h0000 && !cmd_ph_reg && op_reg != FIQ_OP_CMD) begin
            st_next = FIQ_ST_READ;
            busy_next = 1'b1;
            dout_next = 16'h0000;
          end
          if (cmd_ph_reg && dout_reg == 16'h0000) begin
            // Status poll result decides whether identifier command may go
            cmd_ph_next = 1'b0;
            if (ready_next) begin
              st_next = FIQ_ST_CMD;
            end else begin
              refused_next = 1'b1;
              st_next = FIQ_ST_IDLE;
              busy_next = 1'b0;
            end
          end else if (cmd_ph_reg) begin
            dout_next = 16'h0000;
          end
        end
      end
    endcase
  end
  // Sequencer registers
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      st_reg <= FIQ_ST_IDLE;
      op_reg <= FIQ_OP_ARRAY;
      mode_reg <= FIQ_MODE_ARRAY;
      tgt_reg <= '0;
      addr_reg <= '0;
      dout_reg <= 16'h0000;
      data_reg <= 16'h0000;
      busy_reg <= 1'b0;
      refused_reg <= 1'b0;
      locked_reg <= 1'b0;
      ready_reg <= 1'b0;
      stat_valid_reg <= 1'b0;
      cmd_ph_reg <= 1'b0;
      prot_reg <= 16'h0000;
      page_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      op_reg <= op_next;
      mode_reg <= mode_next;
      tgt_reg <= tgt_next;
      addr_reg <= addr_next;
      dout_reg <= dout_next;
      data_reg <= data_next;
      busy_reg <= busy_next;
      refused_reg <= refused_next;
      locked_reg <= locked_next;
      ready_reg <= ready_next;
      stat_valid_reg <= stat_valid_next;
      cmd_ph_reg <= cmd_ph_next;
      prot_reg <= prot_next;
      page_reg <= page_next;
    end
  end
  // ----------------------------------------------------------------
  // Pin registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_dq_oe_n <= 1'b1;
      o_addr <= '0;
      o_dq_out <= 16'h0000;
    end else begin
      o_ce_n <= ce_n_w;
      o_oe_n <= oe_n_w;
      o_we_n <= we_n_w;
      o_dq_oe_n <= dqoe_n_w;
      o_addr <= addr_reg;
      o_dq_out <= dout_reg;
    end
  end
  // ----------------------------------------------------------------
  // Register read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  logic [31:0] rd_next; // Read mux
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (i_reg_addr)
      `FIQ_REG_CTRL: rd_next = {29'h0, op_reg};
      `FIQ_REG_ADDR: rd_next = 32'(tgt_reg);
      `FIQ_REG_STAT: rd_next = {24'h0, mode_reg, stat_valid_reg, ready_reg, locked_reg, refused_reg, 1'b0, busy_reg};
      `FIQ_REG_DATA: rd_next = {16'h0, data_reg};
      `FIQ_REG_PAGE: rd_next = {24'h0, page_reg};
      `FIQ_REG_PROT: rd_next = {16'h0, prot_reg};
      default: rd_next = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 32'h0000_0000;
    end else begin
      o_reg_rdata <= i_reg_read ? rd_next : 32'h0000_0000;
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ONE_STROBE: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !(!o_oe_n && !o_we_n)) else $error("oe and we low together");
  AST_DESELECT: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    $rose(o_ce_n) |-> o_ce_n [*2]) else $error("chip select not held high");
  AST_DRIVE_WRITE: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !o_we_n |-> !o_dq_oe_n) else $error("write without driving data");
  AST_NO_DRIVE_READ: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !o_oe_n |-> o_dq_oe_n) else $error("driving data during read");
  AST_ID_LOWBYTE: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (cyc_sample && mode_reg == FIQ_MODE_ID) |=> data_reg[15:8] == 8'h00) else $error("id high byte");
  AST_BUSY_MASK: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (cyc_sample && mode_reg == FIQ_MODE_STATUS && !dq_s2_reg[7]) |=> data_reg[6:0] == 7'h00)
    else $error("busy status bits kept");
  AST_MODE_CMD: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (mode_reg != $past(mode_reg)) |-> $past(st_reg) == FIQ_ST_CMD) else $error("mode changed without command");
  AST_START_IDLE: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    cyc_start |-> !cyc_busy) else $error("bus cycle started while one runs");
  AST_ID_A0: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (!o_oe_n && mode_reg == FIQ_MODE_ID) |-> !o_addr[0]) else $error("id read with A0 set");
endmodule : fiq_ctrl
`default_nettype wire

// ==== sim/fiq_flash_model.sv ====
// Behavioural flash device answering the controller's strobes
`timescale 1ns/100ps
`default_nettype none
`include "fiq_defs.svh"
module fiq_flash_model
  import fiq_pkg::*;
#(
  parameter logic [7:0] MANUF_CODE = 8'h5A, // Arbitrary identity value
  parameter logic [7:0] DEV_CODE = 8'hC3, // Arbitrary identity value
  parameter logic [6:0] STAT_LOW = 7'h02 // Low status bits when ready
) (
  input wire logic i_clock,
  input wire logic i_engine_busy,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_dq_out,
  input wire logic i_dq_oe_n,
  output logic [15:0] o_dq_in,
  output var fiq_mode_e o_mode,
  output var int o_id_cmds,
  output var int o_latches
);
  logic [15:0] noise_reg = 16'h1234; // Undriven pins wander, never hold
  logic [7:0] stat_latch = 8'hFF; // Output latch for status
  logic [15:0] val; // Value the device drives
  logic [15:0] mask; // Pins actually driven
  logic [7:0] word; // Word offset, A1 lowest
  initial begin
    o_mode = FIQ_MODE_ARRAY;
    o_id_cmds = 0;
    o_latches = 0;
  end
  // ------------------------------------------------
  // Floating pins
  // ------------------------------------------------
  always @(posedge i_clock) begin
    noise_reg <= noise_reg + 16'h3A5B;
  end
  // ------------------------------------------------
  // Command capture; supply level plays no part
  // ------------------------------------------------
  always @(posedge (i_ce_n | i_we_n)) begin
    case (i_dq_oe_n ? noise_reg[7:0] : i_dq_out[7:0])
      8'hFF: o_mode = FIQ_MODE_ARRAY;
      8'h90: begin
        if (!i_engine_busy) begin
          o_mode = FIQ_MODE_ID;
          o_id_cmds++;
        end
      end
      8'h70: o_mode = FIQ_MODE_STATUS;
      8'h98: o_mode = FIQ_MODE_QUERY;
      default: ; // Unknown byte leaves mode alone
    endcase
  end
  // ------------------------------------------------
  // Status latched when output first enabled
  // ------------------------------------------------
  always @(negedge (i_ce_n | i_oe_n)) begin
    stat_latch = i_engine_busy ? 8'h00 : {1'b1, STAT_LOW};
    o_latches++;
  end
  // ------------------------------------------------
  // Read path, single random reads only
  // ------------------------------------------------
  always_comb begin
    word = i_addr[8:1];
    val = 16'h0000;
    mask = (i_ce_n | i_oe_n) ? 16'h0000 : 16'hFFFF;
    if (i_engine_busy || o_mode == FIQ_MODE_STATUS) begin
      val = {8'h00, stat_latch};
      if (i_engine_busy) mask = mask & 16'h0080;
    end else if (o_mode == FIQ_MODE_ID) begin
      case (word)
        8'h00: val = {8'h00, MANUF_CODE};
        8'h01: val = {8'h00, DEV_CODE};
        8'h02: val = {15'h0000, i_addr[23:17] == 7'h01};
        default: val = 16'h0000;
      endcase
    end else if (o_mode == FIQ_MODE_QUERY) begin
      case (word)
        8'h3F: val = 16'h0001;
        8'h40: val = 16'h0000;
        8'h44: val = 16'h0003;
        8'h45: val = 16'h0000;
        default: mask = 16'h0000;
      endcase
    end else begin
      val = i_addr[15:0] ^ 16'hA5C3; // Array pattern
    end
    o_dq_in = (val & mask) | (noise_reg & ~mask);
  end
endmodule : fiq_flash_model
`default_nettype wire

// ==== sim/fiq_ctrl_test.sv ====
// Self-checking bench for the flash query controller
`timescale 1ns/100ps
`default_nettype none
module fiq_ctrl_test;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic busy = 1'b0; // Engine busy, set by scenarios
  logic [31:0] rdata;
  logic ce_n, oe_n, we_n, dq_oe_n;
  logic [23:0] addr;
  logic [15:0] dq_out, dq_in;
  fiq_pkg::fiq_mode_e mode;
  int id_cmds, latches;
  int bad_count = 0;
  int n_tests = 0;
  // ------------------------------------------------
  // Clock, design and device
  // ------------------------------------------------
  initial begin
    forever #4 clock = ~clock;
  end
  fiq_ctrl i_fiq_ctrl (.i_clock(clock), .i_reset_n(reset_n), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_write(reg_write), .i_reg_read(reg_read), .o_reg_rdata(rdata), .o_ce_n(ce_n), .o_oe_n(oe_n),
    .o_we_n(we_n), .o_addr(addr), .o_dq_out(dq_out), .o_dq_oe_n(dq_oe_n), .i_dq_in(dq_in));
  fiq_flash_model i_fiq_flash_model (.i_clock(clock), .i_engine_busy(busy), .i_ce_n(ce_n), .i_oe_n(oe_n),
    .i_we_n(we_n), .i_addr(addr), .i_dq_out(dq_out), .i_dq_oe_n(dq_oe_n), .o_dq_in(dq_in), .o_mode(mode),
    .o_id_cmds(id_cmds), .o_latches(latches));
  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = rdata; // Data stand only this cycle
  endtask : reg_rd
  // Wait for busy to drop, then fetch the result
  task automatic finish_op(output logic [31:0] s, output logic [31:0] d);
    int k;
    for (k = 0; k < 100; k++) begin
      reg_rd(4'h2, s);
      if (s[0] === 1'b0) break;
    end
    if (k == 100) chk("busy timeout", 32'h0, 32'h1);
    reg_rd(4'h3, d);
  endtask : finish_op
  task automatic run(input logic [31:0] op, input logic [31:0] a, output logic [31:0] s, output logic [31:0] d);
    reg_wr(4'h1, a);
    reg_wr(4'h0, op);
    finish_op(s, d);
  endtask : run
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_id;
    logic [31:0] s, d;
    run(1, 32'h0, s, d);
    chk("manufacturer", 32'h5A, {24'h0, d[7:0]});
    run(1, 32'h1, s, d);
    chk("device code", 32'hC3, {24'h0, d[7:0]});
    run(1, 32'h020002, s, d);
    chk("lock locked", 32'h01, {24'h0, d[7:0]});
    chk("stat locked", 32'h1, {31'h0, s[3]});
    run(1, 32'h000002, s, d);
    chk("lock open", 32'h00, {24'h0, d[7:0]});
    chk("mode id", 32'h1, {30'h0, mode});
    chk("id commands", 32'd4, id_cmds);
  endtask : t_id
  task automatic t_query;
    logic [31:0] s, d;
    logic [7:0] qa [5] = '{8'h3F, 8'h40, 8'h44, 8'h45, 8'h46};
    logic [7:0] qv [5] = '{8'h01, 8'h00, 8'h03, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      run(3, {24'h0, qa[i]}, s, d);
      chk("query entry", {24'h0, qv[i]}, {24'h0, d[7:0]});
    end
    reg_rd(4'h4, d);
    chk("page bytes", 32'd8, d);
    reg_rd(4'h5, d);
    chk("prot count", 32'd1, d);
    chk("mode query", 32'h3, {30'h0, mode});
  endtask : t_query
  task automatic t_status;
    logic [31:0] s, d;
    int l0;
    run(0, 32'h0, s, d);
    chk("mode status", 32'h2, {30'h0, mode});
    chk("stat mode", 32'h2, {30'h0, s[7:6]});
    for (int i = 0; i < 2; i++) begin
      l0 = latches;
      run(2, 32'h0, s, d);
      chk("status ready", 32'h82, {24'h0, d[7:0]});
      chk("stat ready", 32'h3, {30'h0, s[5:4]});
      chk("fresh latch", 32'd1, latches - l0);
    end
    @(posedge clock);
    busy <= 1'b1;
    run(2, 32'h0, s, d);
    chk("status busy", 32'h00, {24'h0, d[7:0]});
    chk("stat busy", 32'h0, {30'h0, s[5:4]});
    l0 = id_cmds;
    run(1, 32'h0, s, d);
    chk("refused", 32'h1, {31'h0, s[2]});
    chk("no id cmd", l0, id_cmds);
    run(4, 32'h0, s, d);
    chk("busy array", 32'h0, {31'h0, d[7]});
    @(posedge clock);
    busy <= 1'b0;
  endtask : t_status
  task automatic t_array;
    logic [31:0] s, d;
    int l0;
    l0 = id_cmds;
    reg_wr(4'h1, 32'h000123);
    reg_wr(4'h0, 32'h4);
    reg_wr(4'h0, 32'h1); // Ignored, still busy
    finish_op(s, d);
    chk("array data", 32'hA4E0, {16'h0, d[15:0]});
    chk("mode array", 32'h0, {30'h0, mode});
    chk("no extra id", l0, id_cmds);
    reg_rd(4'hF, d);
    chk("unmapped", 32'h0, d);
  endtask : t_array
  // ------------------------------------------------
  // Verdict and sequence
  // ------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  initial begin
    #400000;
    bad_count++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clock);
    #1 chk("idle strobes", 32'hF, {28'h0, ce_n, oe_n, we_n, dq_oe_n});
    chk("idle rdata", 32'h0, rdata);
    @(posedge clock);
    reset_n <= 1'b1;
    t_id();
    t_query();
    t_status();
    t_array();
    final_report();
  end
endmodule : fiq_ctrl_test
`default_nettype wire
